/* design/frpc_top.sv */
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "frpc_params.svh"
// Function
// - Acknowledged watchdog, voltage or comparator NMI aborts erase/program, resets flash.
// - After abort, NMI service waits a fixed delay; flash then restarts.
// - Watchdog keeps counting during flash commands and may abort them.
// - Flash stop bit set blocks every flash array access.
// - Stop or wait with rewrite disabled powers flash off automatically.
// - Leaving stop or wait restores flash power automatically.
// - Low-current read enable in low-speed modes reduces read current.
// - Ready flag reads 0 during program or erase, 1 when finished.
// - Program starts on command 40h then a data byte write.
module frpc_top
    import frpc_pkg::*;
#(
    parameter int PROG_CYC  = `FRPC_PROG_CYC,
    parameter int ERASE_CYC = `FRPC_ERASE_CYC
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // System state
    input  wire logic        nmi_ack_in,
    input  wire logic        stop_mode_in,
    input  wire logic        wait_mode_in,
    input  wire logic        low_speed_mode_in,
    input  wire logic        array_req_in,
    // Flash array control
    output logic             array_grant_out,
    output logic             flash_power_out,
    output logic             array_reset_out,
    output logic             low_current_out,
    output logic             nmi_release_out,
    output logic             irq_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int TW = 24;
    frpc_state_t            state, next_state;
    frpc_ctrl_t             ctrl, next_ctrl;
    frpc_apb_req_t          req;
    logic [`FRPC_IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [`FRPC_IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [31:0]            next_prdata;
    logic                   next_pready, next_pslverr;
    logic                   armed_rmsel, armed_blken, armed_ctrl2;
    logic                   next_armed_rmsel, next_armed_blken;
    logic                   next_armed_ctrl2;
    logic                   t_load, t_clear, t_expired;
    logic [TW-1:0]          t_count;
    logic                   next_grant, next_power, next_areset;
    logic                   next_lowcur, next_nmi_rel, next_irq;
    logic                   wr_acc, rd_acc, ready_flag, pwr_ok;
    logic [`FRPC_IRQ_W-1:0] ev;
    logic                   unmapped;

    // Bus request bundled so the decode reads one carrier
    assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                   paddr: paddr_in, pwdata: pwdata_in};
    // One-wait-state slave: write taken when pready already high, read taken in the wait cycle
    assign wr_acc = req.psel & req.penable & pready_out & req.pwrite;
    assign rd_acc = req.psel & req.penable & ~pready_out & ~req.pwrite;
    assign ready_flag = (state == FRPC_IDLE) || (state == FRPC_PROG_AR)
                        || (state == FRPC_ERA_AR);
    // Power drops in stop/wait unless CPU rewrite is enabled
    assign pwr_ok = ~((stop_mode_in | wait_mode_in)
                      & ~ctrl.rewrite_mode_select_bit);
    // Offsets off the map answer with an error; a write there only disarms the 0-then-1 sequence
    assign unmapped = !(req.paddr inside {`FRPC_OFF_MODE0, `FRPC_OFF_MODE1,
        `FRPC_OFF_MODE4, `FRPC_OFF_CMD, `FRPC_OFF_STATUS,
        `FRPC_OFF_IRQ_STAT, `FRPC_OFF_IRQ_MASK});

    // One timer serves both the operation and the recovery delay
    frpc_timer #(.W(TW)) u_timer (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .load_in     (t_load),
        .count_in    (t_count),
        .clear_in    (t_clear),
        .expired_out (t_expired)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Watchdog runs on outside the block, so its NMI can land here
    always_comb begin
        next_state = state;
        t_load     = 1'b0;
        t_clear    = 1'b0;
        t_count    = '0;
        ev         = '0;
        unique case (state)
            FRPC_IDLE: begin
                if (wr_acc && req.paddr == `FRPC_OFF_CMD
                    && ctrl.rewrite_mode_select_bit) begin
                    if (req.pwdata[7:0] == `FRPC_CMD_PROGRAM) begin
                        next_state = FRPC_PROG_AR;
                    end else if (req.pwdata[7:0] == `FRPC_CMD_ERASE) begin
                        next_state = FRPC_ERA_AR;
                    end
                end
            end
            FRPC_PROG_AR: begin
                if (wr_acc && req.paddr == `FRPC_OFF_CMD) begin
                    next_state = FRPC_BUSY;
                    t_load     = 1'b1;
                    t_count    = TW'(PROG_CYC);
                end
            end
            FRPC_ERA_AR: begin
                if (wr_acc && req.paddr == `FRPC_OFF_CMD) begin
                    if (req.pwdata[7:0] == `FRPC_CMD_CONFIRM) begin
                        next_state = FRPC_BUSY;
                        t_load     = 1'b1;
                        t_count    = TW'(ERASE_CYC);
                    end else begin
                        next_state = FRPC_IDLE;
                    end
                end
            end
            FRPC_BUSY: begin
                if (nmi_ack_in) begin
                    next_state = FRPC_RECOVER;
                    t_load     = 1'b1;
                    t_count    = TW'(`FRPC_NMI_CYC);
                    ev[`FRPC_BIT_ABORT] = 1'b1;
                end else if (t_expired) begin
                    next_state = FRPC_IDLE;
                    ev[`FRPC_BIT_DONE] = 1'b1;
                end
            end
            FRPC_RECOVER: begin
                if (t_expired) begin
                    next_state = FRPC_IDLE;
                end
            end
            default: begin
                next_state = FRPC_IDLE;
                t_clear    = 1'b1;
            end
        endcase
        if (pwr_ok == 1'b0 && flash_power_out) begin
            ev[`FRPC_BIT_PWRDN] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers and bus
    // ------------------------------------------------------------
    // A 1 in the rewrite select, block enable or second control bit only sticks when armed by a prior 0 write
    always_comb begin
        next_ctrl        = ctrl;
        next_armed_rmsel = armed_rmsel;
        next_armed_blken = armed_blken;
        next_armed_ctrl2 = armed_ctrl2;
        next_irq_mask    = irq_mask;
        next_irq_stat    = irq_stat;
        next_prdata      = prdata_out;
        next_pready      = req.psel & req.penable & ~pready_out;
        // Error decided early so it stands together with pready
        next_pslverr     = next_pready & unmapped;
        if (wr_acc) begin
            unique case (req.paddr)
                `FRPC_OFF_MODE0: begin
                    if (!req.pwdata[`FRPC_BIT_RMSEL]) begin
                        next_ctrl.rewrite_mode_select_bit = 1'b0;
                        next_armed_rmsel = 1'b1;
                    end else if (armed_rmsel) begin
                        next_ctrl.rewrite_mode_select_bit = 1'b1;
                    end else begin
                        next_irq_stat[`FRPC_BIT_ARMERR] = 1'b1;
                    end
                    if (!req.pwdata[`FRPC_BIT_BLKEN]) begin
                        next_ctrl.block_rewrite_enable_bit = 1'b0;
                        next_armed_blken = 1'b1;
                    end else if (armed_blken) begin
                        next_ctrl.block_rewrite_enable_bit = 1'b1;
                    end
                    next_ctrl.flash_stop_bit =
                        req.pwdata[`FRPC_BIT_STOP];
                end
                `FRPC_OFF_MODE1: begin
                    if (!req.pwdata[`FRPC_BIT_CTRL2]) begin
                        next_ctrl.second_rewrite_control_bit = 1'b0;
                        next_armed_ctrl2 = 1'b1;
                    end else if (armed_ctrl2) begin
                        next_ctrl.second_rewrite_control_bit = 1'b1;
                    end
                end
                `FRPC_OFF_MODE4: begin
                    next_ctrl.low_current_read_enable =
                        req.pwdata[`FRPC_BIT_LOWCUR];
                end
                `FRPC_OFF_IRQ_STAT: begin
                    next_irq_stat = irq_stat & ~req.pwdata[`FRPC_IRQ_W-1:0];
                end
                `FRPC_OFF_IRQ_MASK: begin
                    next_irq_mask = req.pwdata[`FRPC_IRQ_W-1:0];
                end
                `FRPC_OFF_CMD: ;
                default: ; // Unmapped: error raised in the first access cycle; STATUS write ignored
            endcase
            // Any other write disarms the 0-then-1 sequence
            if (req.paddr != `FRPC_OFF_MODE0) begin
                next_armed_rmsel = 1'b0;
                next_armed_blken = 1'b0;
            end
            if (req.paddr != `FRPC_OFF_MODE1) begin
                next_armed_ctrl2 = 1'b0;
            end
        end
        // Set beats clear
        next_irq_stat = next_irq_stat | ev;
        // Read data taken in the first access cycle, held to the next read
        if (rd_acc) begin
            unique case (req.paddr)
                `FRPC_OFF_MODE0: next_prdata = {28'h0000000,
                    ctrl.flash_stop_bit, ctrl.block_rewrite_enable_bit,
                    ctrl.rewrite_mode_select_bit, ready_flag};
                `FRPC_OFF_MODE1: next_prdata = {30'h0000000,
                    ctrl.second_rewrite_control_bit, 1'b0};
                `FRPC_OFF_MODE4: next_prdata = {24'h000000,
                    ctrl.low_current_read_enable, 7'h00};
                `FRPC_OFF_STATUS: next_prdata = {29'h0000000, state};
                `FRPC_OFF_IRQ_STAT: next_prdata = {28'h0000000, irq_stat};
                `FRPC_OFF_IRQ_MASK: next_prdata = {28'h0000000, irq_mask};
                `FRPC_OFF_CMD: next_prdata = 32'h00000000;
                default: begin
                    next_prdata  = 32'h00000000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        // Grant and flash reset both follow next_state, never together
        next_grant   = array_req_in & ~ctrl.flash_stop_bit & pwr_ok
                       & (next_state == FRPC_IDLE);
        next_power   = pwr_ok;
        next_areset  = (next_state == FRPC_RECOVER);
        next_lowcur  = ctrl.low_current_read_enable
                       & low_speed_mode_in;
        next_nmi_rel = (state == FRPC_RECOVER) & t_expired;
        next_irq     = |(next_irq_stat & next_irq_mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Every output leaves a flip-flop; reset keeps the flash powered
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state           <= FRPC_IDLE;
            ctrl            <= '0;
            armed_rmsel     <= 1'b0;
            armed_blken     <= 1'b0;
            armed_ctrl2     <= 1'b0;
            irq_stat        <= '0;
            irq_mask        <= '0;
            prdata_out      <= 32'h00000000;
            pready_out      <= 1'b0;
            pslverr_out     <= 1'b0;
            array_grant_out <= 1'b0;
            flash_power_out <= 1'b1;
            array_reset_out <= 1'b0;
            low_current_out <= 1'b0;
            nmi_release_out <= 1'b0;
            irq_out         <= 1'b0;
        end else begin
            state           <= next_state;
            ctrl            <= next_ctrl;
            armed_rmsel     <= next_armed_rmsel;
            armed_blken     <= next_armed_blken;
            armed_ctrl2     <= next_armed_ctrl2;
            irq_stat        <= next_irq_stat;
            irq_mask        <= next_irq_mask;
            prdata_out      <= next_prdata;
            pready_out      <= next_pready;
            pslverr_out     <= next_pslverr;
            array_grant_out <= next_grant;
            flash_power_out <= next_power;
            array_reset_out <= next_areset;
            low_current_out <= next_lowcur;
            nmi_release_out <= next_nmi_rel;
            irq_out         <= next_irq;
        end
    end
endmodule // frpc_top

/* design/frpc_params.svh */
`ifndef FRPC_PARAMS_SVH
`define FRPC_PARAMS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define FRPC_OFF_MODE0     8'h00
`define FRPC_OFF_MODE1     8'h04
`define FRPC_OFF_MODE4     8'h08
`define FRPC_OFF_CMD       8'h0C
`define FRPC_OFF_STATUS    8'h10
`define FRPC_OFF_IRQ_STAT  8'h14
`define FRPC_OFF_IRQ_MASK  8'h18
`define FRPC_OFF_CTRL      8'h1C
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define FRPC_BIT_READY     0
`define FRPC_BIT_RMSEL     1
`define FRPC_BIT_BLKEN     2
`define FRPC_BIT_STOP      3
`define FRPC_BIT_CTRL2     1
`define FRPC_BIT_LOWCUR    7
`define FRPC_BIT_DONE      0
`define FRPC_BIT_ABORT     1
`define FRPC_BIT_ARMERR    2
`define FRPC_BIT_PWRDN     3
// ------------------------------------------------------------
// Commands and timing
// ------------------------------------------------------------
`define FRPC_CMD_PROGRAM   8'h40
`define FRPC_CMD_ERASE     8'h20
`define FRPC_CMD_CONFIRM   8'hD0
`define FRPC_PROG_NS       400000
`define FRPC_ERASE_NS      9000000
`define FRPC_NMI_NS        1000
`define FRPC_CLK_NS        50
`define FRPC_PROG_CYC      (`FRPC_PROG_NS / `FRPC_CLK_NS)
`define FRPC_ERASE_CYC     (`FRPC_ERASE_NS / `FRPC_CLK_NS)
`define FRPC_NMI_CYC       (`FRPC_NMI_NS / `FRPC_CLK_NS)
`define FRPC_IRQ_W         4
`endif

/* design/frpc_pkg.sv */
package frpc_pkg;
    typedef enum logic [2:0] {
        FRPC_IDLE    = 3'b000,
        FRPC_PROG_AR = 3'b001,
        FRPC_ERA_AR  = 3'b010,
        FRPC_BUSY    = 3'b011,
        FRPC_RECOVER = 3'b100
    } frpc_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } frpc_apb_req_t;

    typedef struct packed {
        logic rewrite_mode_select_bit;
        logic block_rewrite_enable_bit;
        logic flash_stop_bit;
        logic second_rewrite_control_bit;
        logic low_current_read_enable;
    } frpc_ctrl_t;
endpackage

/* design/frpc_timer.sv */
`timescale 1ns/1ns
// Down counter that times one flash operation or recovery delay
module frpc_timer #(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    // Control
    input  wire logic         load_in,
    input  wire logic [W-1:0] count_in,
    input  wire logic         clear_in,
    // Status
    output logic              expired_out
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // Load wins over clear; the count stops at zero
    always_comb begin
        next_cnt = cnt;
        if (load_in) begin
            next_cnt = count_in;
        end else if (clear_in) begin
            next_cnt = '0;
        end else if (cnt != '0) begin
            next_cnt = cnt - W'(1);
        end
    end

    // Last counted cycle flagged at once, so a load of N lasts N cycles
    assign expired_out = (cnt == W'(1));

    // Counter register
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule // frpc_timer

/* test/frpc_props.sv */
`timescale 1ns/1ns
`include "frpc_params.svh"
// ----------------------------------------
// Port checker for the flash controller
// ----------------------------------------
module frpc_props (
    // Clock, reset and bus
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic       psel_in,
    input wire logic       penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic       pready_out,
    input wire logic       pslverr_out,
    // System state and flash side
    input wire logic       nmi_ack_in,
    input wire logic       stop_mode_in,
    input wire logic       wait_mode_in,
    input wire logic       low_speed_mode_in,
    input wire logic       array_grant_out,
    input wire logic       flash_power_out,
    input wire logic       array_reset_out,
    input wire logic       low_current_out,
    input wire logic       nmi_release_out
);
    localparam logic [7:0] REC_LEN = 8'(`FRPC_NMI_CYC);
    logic [7:0] rec_len;
    logic [7:0] next_rec_len;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Recovery length, held until the release pulse so it can be judged
    always_comb begin
        next_rec_len = rec_len;
        if (array_reset_out)
            next_rec_len = rec_len + 8'h01;
        else if (nmi_release_out)
            next_rec_len = 8'h00;
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in)
            rec_len <= 8'h00;
        else
            rec_len <= next_rec_len;
    end
    sequence s_access_wait;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_recover_hold;
        array_reset_out [*8];
    endsequence
    a_pready_after_wait: assert property (s_access_wait |=> pready_out)
        else $error("pready missing after wait state");
    a_pready_single: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_unmapped_error: assert property (pready_out &&
        paddr_in == `FRPC_OFF_CTRL |-> pslverr_out)
        else $error("unmapped access without error");
    a_abort_cause: assert property ($rose(array_reset_out) |->
        $past(nmi_ack_in) || $past(nmi_ack_in, 2))
        else $error("flash reset without interrupt");
    a_recover_hold: assert property ($rose(array_reset_out) |->
        s_recover_hold) else $error("flash reset too short");
    a_release_delay: assert property (nmi_release_out |->
        rec_len == REC_LEN) else $error("recovery delay wrong");
    a_release_after: assert property ($fell(array_reset_out) |->
        ##[0:2] nmi_release_out) else $error("no release pulse");
    a_no_grant_reset: assert property (array_reset_out |->
        !array_grant_out) else $error("access during flash reset");
    a_grant_powered: assert property ((!flash_power_out) [*2] |->
        !array_grant_out) else $error("access with power off");
    a_power_restore: assert property (!stop_mode_in &&
        !wait_mode_in |=> flash_power_out) else $error("power not back");
    a_low_current_mode: assert property (!low_speed_mode_in |=>
        !low_current_out) else $error("low current at high speed");
endmodule // frpc_props

/* test/test_flash_rewrite_power_control.sv */
`timescale 1ns/1ns
`include "frpc_params.svh"
module test_flash_rewrite_power_control;
    // Short operation times keep the run brief
    localparam int PROG = 10;
    logic        clk_in = 1'b0, reset_in = 1'b1;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rdata;
    logic        pready_out, pslverr_out, rerr;
    logic        nmi_ack_in = 1'b0, stop_mode_in = 1'b0;
    logic        wait_mode_in = 1'b0, low_speed_mode_in = 1'b0;
    logic        array_req_in = 1'b0, array_grant_out, flash_power_out;
    logic        array_reset_out, low_current_out, nmi_release_out, irq_out;
    int          errors = 0, comparisons = 0;
    always #25 clk_in = ~clk_in;
    frpc_top #(.PROG_CYC(PROG), .ERASE_CYC(20)) i_dut (.clk_in, .reset_in,
        .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .nmi_ack_in, .stop_mode_in,
        .wait_mode_in, .low_speed_mode_in, .array_req_in, .array_grant_out,
        .flash_power_out, .array_reset_out, .low_current_out,
        .nmi_release_out, .irq_out);
    // ----------------------------------------
    // Compare, bus and timing helpers
    // ----------------------------------------
    task automatic check32(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic check1(input logic got, exp, input string what);
        check32({31'h0, got}, {31'h0, exp}, what);
    endtask
    // One transfer; an idle edge first so no strobe is assigned twice
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        check1(pready_out, 1'b1, "bus answer");
        rdata = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_in);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_access;
        check1(flash_power_out, 1'b1, "power after reset");
        rd(`FRPC_OFF_CTRL);
        check1(rerr, 1'b1, "unmapped error");
        check32(rdata, 32'h0, "unmapped data");
        wr(`FRPC_OFF_CTRL, 32'hFFFFFFFF);
        check1(rerr, 1'b1, "unmapped write error");
        wr(`FRPC_OFF_IRQ_MASK, 32'h0);
        wr(`FRPC_OFF_MODE1, 32'h0);
        wr(`FRPC_OFF_MODE0, 32'h00000002);
        rd(`FRPC_OFF_MODE0);
        check1(rdata[`FRPC_BIT_RMSEL], 1'b0, "select refused");
        rd(`FRPC_OFF_IRQ_STAT);
        check1(rdata[`FRPC_BIT_ARMERR], 1'b1, "arm error");
        check1(irq_out, 1'b0, "irq masked");
        wr(`FRPC_OFF_IRQ_MASK, 32'h0000000F);
        settle;
        check1(irq_out, 1'b1, "irq raised");
        wr(`FRPC_OFF_IRQ_STAT, 32'h00000004);
        settle;
        check1(irq_out, 1'b0, "irq cleared");
        wr(`FRPC_OFF_MODE0, 32'h0);
        // Rewrite mode and block rewrite entered by 0-then-1 writes
        wr(`FRPC_OFF_MODE0, 32'h00000006);
        wr(`FRPC_OFF_MODE1, 32'h0);
        wr(`FRPC_OFF_MODE1, 32'h00000002);
        rd(`FRPC_OFF_MODE0);
        check32(rdata & 32'h0000000E, 32'h00000006, "mode bits");
        rd(`FRPC_OFF_MODE1);
        check1(rdata[`FRPC_BIT_CTRL2], 1'b1, "second control");
        $display("test access done");
    endtask
    task automatic t_program;
        array_req_in <= 1'b1;
        settle;
        check1(array_grant_out, 1'b1, "grant idle");
        wr(`FRPC_OFF_CMD, 32'h00000040);
        wr(`FRPC_OFF_CMD, 32'h0000005A);
        rd(`FRPC_OFF_MODE0);
        check1(rdata[`FRPC_BIT_READY], 1'b0, "busy flag");
        check1(array_grant_out, 1'b0, "no grant busy");
        repeat (PROG) @(posedge clk_in);
        rd(`FRPC_OFF_MODE0);
        check1(rdata[`FRPC_BIT_READY], 1'b1, "ready again");
        rd(`FRPC_OFF_IRQ_STAT);
        check1(rdata[`FRPC_BIT_DONE], 1'b1, "done event");
        wr(`FRPC_OFF_IRQ_STAT, 32'h0000000F);
        $display("test program done");
    endtask
    task automatic t_abort;
        int n;
        nmi_ack_in <= 1'b1;
        @(posedge clk_in);
        nmi_ack_in <= 1'b0;
        settle;
        check1(array_reset_out, 1'b0, "idle no abort");
        wr(`FRPC_OFF_CMD, 32'h00000020);
        wr(`FRPC_OFF_CMD, 32'h00000011);
        rd(`FRPC_OFF_MODE0);
        check1(rdata[`FRPC_BIT_READY], 1'b1, "erase cancelled");
        wr(`FRPC_OFF_CMD, 32'h00000020);
        // Erase confirmed with D0h, so an NMI may now abort it
        wr(`FRPC_OFF_CMD, 32'h000000D0);
        // The watchdog keeps running and fires mid-erase
        @(posedge clk_in);
        nmi_ack_in <= 1'b1;
        @(posedge clk_in);
        nmi_ack_in <= 1'b0;
        n = 0;
        while (array_reset_out !== 1'b1 && n < 5) begin
            @(posedge clk_in);
            n++;
        end
        check1(array_reset_out, 1'b1, "abort reset");
        n = 0;
        while (array_reset_out === 1'b1 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        check32(32'(n), 32'(`FRPC_NMI_CYC), "recovery span");
        n = 0;
        while (nmi_release_out !== 1'b1 && n < 4) begin
            @(posedge clk_in);
            n++;
        end
        check1(nmi_release_out, 1'b1, "release pulse");
        rd(`FRPC_OFF_IRQ_STAT);
        check1(rdata[`FRPC_BIT_ABORT], 1'b1, "abort event");
        rd(`FRPC_OFF_MODE0);
        check1(rdata[`FRPC_BIT_READY], 1'b1, "flash restarted");
        check1(array_grant_out, 1'b1, "grant restored");
        wr(`FRPC_OFF_IRQ_STAT, 32'h0000000F);
        $display("test abort done");
    endtask
    task automatic t_power;
        wait_mode_in <= 1'b1;
        settle;
        check1(flash_power_out, 1'b1, "power kept");
        wr(`FRPC_OFF_MODE0, 32'h0);
        settle;
        check1(flash_power_out, 1'b0, "off in wait");
        check1(array_grant_out, 1'b0, "no grant off");
        rd(`FRPC_OFF_IRQ_STAT);
        check1(rdata[`FRPC_BIT_PWRDN], 1'b1, "power event");
        wait_mode_in <= 1'b0;
        settle;
        check1(flash_power_out, 1'b1, "on after wait");
        stop_mode_in <= 1'b1;
        settle;
        check1(flash_power_out, 1'b0, "off in stop");
        stop_mode_in <= 1'b0;
        settle;
        check1(flash_power_out, 1'b1, "on after stop");
        wr(`FRPC_OFF_MODE0, 32'h00000008);
        settle;
        check1(array_grant_out, 1'b0, "stopped flash");
        wr(`FRPC_OFF_MODE0, 32'h0);
        settle;
        check1(array_grant_out, 1'b1, "flash running");
        $display("test power done");
    endtask
    task automatic t_low_current;
        wr(`FRPC_OFF_MODE4, 32'h00000080);
        settle;
        check1(low_current_out, 1'b0, "high speed");
        low_speed_mode_in <= 1'b1;
        settle;
        check1(low_current_out, 1'b1, "low current on");
        wr(`FRPC_OFF_MODE4, 32'h0);
        settle;
        check1(low_current_out, 1'b0, "low current off");
        $display("test low current done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        t_access;
        t_program;
        t_abort;
        t_power;
        t_low_current;
        wrap_up;
    end
    // Watchdog: the scenarios need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        errors++;
        wrap_up;
    end
endmodule // test_flash_rewrite_power_control
bind frpc_top frpc_props i_props (.clk_in, .reset_in, .psel_in,
    .penable_in, .paddr_in, .pready_out, .pslverr_out, .nmi_ack_in,
    .stop_mode_in, .wait_mode_in, .low_speed_mode_in, .array_grant_out,
    .flash_power_out, .array_reset_out, .low_current_out, .nmi_release_out);
